/* File: inc/drwa_params.svh */
// constants for the display ram write addressing block
`ifndef DRWA_PARAMS_SVH
`define DRWA_PARAMS_SVH
// register byte offsets
`define DRWA_OFF_CMD     8'h00
`define DRWA_OFF_DATA    8'h04
`define DRWA_OFF_PTR     8'h08
`define DRWA_OFF_CFG     8'h0C
// command codes
`define DRWA_CODE_DISPLAY_CONTROL_CMD  8'h10
`define DRWA_CODE_DIR    8'h11
`define DRWA_CODE_SCAN   8'h12
`define DRWA_CODE_GSINC  8'h20
`define DRWA_CODE_XSTART 8'h21
`define DRWA_CODE_YSTART 8'h22
// grey_level_select encodings
`define DRWA_MODE_GS16   3'h0
`define DRWA_MODE_GS4    3'h1
`define DRWA_MODE_GS64A  3'h2
`define DRWA_MODE_GS64B  3'h3
`define DRWA_MODE_MONO   3'h4
// pointer limits per mode
`define DRWA_XMAX_GS16   8'h7F
`define DRWA_YMAX_GS16   8'h47
`define DRWA_XMAX_GS4    8'h3F
`define DRWA_YMAX_GS4    8'h8F
`define DRWA_XMAX_GS64A  8'h7F
`define DRWA_YMAX_GS64A  8'h47
`define DRWA_XMAX_GS64B  8'hFF
`define DRWA_YMAX_GS64B  8'h23
`define DRWA_XMAX_MONO   8'h3F
`define DRWA_YMAX_MONO   8'h8F
// command data bit positions
`define DRWA_GS_X_AUTO_STEP_BIT 4
`define DRWA_GS_Y_AUTO_STEP_BIT 5
`define DRWA_DC_ON_BIT   0
`define DRWA_DC_TWO_BIT  1
`define DRWA_DIR_VF_BIT  0
`define DRWA_DIR_HF_BIT  1
// status/config read field positions
`define DRWA_CFG_X_AUTO_STEP    4
`define DRWA_CFG_Y_AUTO_STEP    5
`define DRWA_CFG_HF      8
`define DRWA_CFG_VF      9
`define DRWA_CFG_ON      16
`define DRWA_CFG_TWO     17
`define DRWA_CFG_SCAN    24
`define DRWA_PTR_Y       8
// reset values
`define DRWA_RST_MODE    3'h0
`define DRWA_RST_SCAN    7'h47
`define DRWA_RST_PTR     8'h00
`endif

/* File: inc/drwa_pkg.sv */
// types for the display ram write addressing block
`include "drwa_params.svh"
package drwa_pkg;
  typedef enum logic [2:0] {
    DRWA_GS16  = `DRWA_MODE_GS16,
    DRWA_GS4   = `DRWA_MODE_GS4,
    DRWA_GS64A = `DRWA_MODE_GS64A,
    DRWA_GS64B = `DRWA_MODE_GS64B,
    DRWA_MONO  = `DRWA_MODE_MONO
  } drwa_mode_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] data;
  } drwa_ram_wr_t;
  typedef struct packed {
    logic       display_on_bit;
    logic       vertical_flip;
    logic       two_colour_en;
    logic [2:0] grey_level_select;
    logic [6:0] scan_line_count;
  } drwa_disp_t;
endpackage

/* File: rtl/drwa_top.sv */
// display ram write addressing and display control, apb slave
// Contract
// - grey64 mode2: x 00..FF, y 00..23
// - grey64 mode2: one 6-bit pixel per byte
// - no two-colour option in grey64 mode2
// - mono: x 00..3F, y 00..8F
// - mono: eight bits, bit0 is pixel0
// - mono allows two-colour option
// - grey_level_select chooses memory organisation
// - no step bits: pointers stay
// - y step only: y advances
// - x step only: x advances
// - both steps: both advance, y alone past limit
// - horizontal flip applies at write time
// - command 11h holds vertical and horizontal flip
// - command 10h display on, cleared at reset
// - command 12h sets scanned row count
// - start commands load x and y pointers
// - grey16: x 00..7F, y 00..47, two nibbles
// - grey4: x 00..3F, y 00..8F, four pixels
// - grey64 mode1: x 00..7F, y 00..47, 6-bit
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "drwa_params.svh"
module drwa_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // display ram write port
  output drwa_pkg::drwa_ram_wr_t     ram_wr,
  // display control state
  output drwa_pkg::drwa_disp_t       disp
);

  ////////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state so read data comes from a flop
  typedef enum logic [1:0] {
    DRWA_ST_IDLE = 2'b01,
    DRWA_ST_ACK  = 2'b10
  } drwa_st_t;

  drwa_st_t    st_r;
  drwa_st_t    st_nxt;
  logic        acc;
  logic        done;
  logic        hit_cmd;
  logic        hit_data;
  logic        hit_ptr;
  logic        hit_cfg;
  logic        mapped;
  logic        wr_cmd;
  logic        wr_data;
  logic [7:0]  code;
  logic [7:0]  arg;
  logic [31:0] rd_val;
  logic        err_r;
  logic [31:0] rdata_r;

  assign acc      = psel && penable;
  assign hit_cmd  = (paddr == ADDR_W'(`DRWA_OFF_CMD));
  assign hit_data = (paddr == ADDR_W'(`DRWA_OFF_DATA));
  assign hit_ptr  = (paddr == ADDR_W'(`DRWA_OFF_PTR));
  assign hit_cfg  = (paddr == ADDR_W'(`DRWA_OFF_CFG));
  assign mapped   = hit_cmd || hit_data || hit_ptr || hit_cfg;
  assign done     = acc && (st_r == DRWA_ST_ACK);
  assign pready   = done;
  assign pslverr  = done && err_r;
  assign prdata   = rdata_r;
  // partial strobes would split a command word, so low lanes must be written
  assign wr_cmd   = done && pwrite && hit_cmd && pstrb[1] && pstrb[0];
  assign wr_data  = done && pwrite && hit_data && pstrb[0];
  assign code     = pwdata[15:8];
  assign arg      = pwdata[7:0];

  always_comb begin
    case (st_r)
      DRWA_ST_IDLE: st_nxt = acc ? DRWA_ST_ACK : DRWA_ST_IDLE;
      DRWA_ST_ACK:  st_nxt = DRWA_ST_IDLE;
      default:      st_nxt = DRWA_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= DRWA_ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else if (acc && st_r == DRWA_ST_IDLE) begin
      rdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      err_r   <= !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration written by commands
  drwa_pkg::drwa_mode_t mode_r;
  logic       x_auto_step_r;
  logic       y_auto_step_r;
  logic       hflip_r;
  logic       vflip_r;
  logic       on_r;
  logic       two_r;
  logic [6:0] scan_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= drwa_pkg::drwa_mode_t'(`DRWA_RST_MODE);
      x_auto_step_r <= 1'b0;
      y_auto_step_r <= 1'b0;
    end else if (wr_cmd && code == `DRWA_CODE_GSINC) begin
      mode_r <= drwa_pkg::drwa_mode_t'(arg[2:0]);
      x_auto_step_r <= arg[`DRWA_GS_X_AUTO_STEP_BIT];
      y_auto_step_r <= arg[`DRWA_GS_Y_AUTO_STEP_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vflip_r <= 1'b0;
      hflip_r <= 1'b0;
    end else if (wr_cmd && code == `DRWA_CODE_DIR) begin
      vflip_r <= arg[`DRWA_DIR_VF_BIT];
      hflip_r <= arg[`DRWA_DIR_HF_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r  <= 1'b0;
      two_r <= 1'b0;
    end else if (wr_cmd && code == `DRWA_CODE_DISPLAY_CONTROL_CMD) begin
      on_r  <= arg[`DRWA_DC_ON_BIT];
      two_r <= arg[`DRWA_DC_TWO_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_r <= `DRWA_RST_SCAN;
    end else if (wr_cmd && code == `DRWA_CODE_SCAN) begin
      scan_r <= arg[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-mode pointer limits
  logic [7:0] xmax;
  logic [7:0] ymax;
  logic       two_ok;

  always_comb begin
    case (mode_r)
      drwa_pkg::DRWA_GS4: begin
        xmax   = `DRWA_XMAX_GS4;
        ymax   = `DRWA_YMAX_GS4;
        two_ok = 1'b1;
      end
      drwa_pkg::DRWA_GS64A: begin
        xmax   = `DRWA_XMAX_GS64A;
        ymax   = `DRWA_YMAX_GS64A;
        two_ok = 1'b0;
      end
      drwa_pkg::DRWA_GS64B: begin
        xmax   = `DRWA_XMAX_GS64B;
        ymax   = `DRWA_YMAX_GS64B;
        two_ok = 1'b0;
      end
      drwa_pkg::DRWA_MONO: begin
        xmax   = `DRWA_XMAX_MONO;
        ymax   = `DRWA_YMAX_MONO;
        two_ok = 1'b1;
      end
      default: begin
        // unused codes fall back to the 16-level layout
        xmax   = `DRWA_XMAX_GS16;
        ymax   = `DRWA_YMAX_GS16;
        two_ok = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pixel packing within a byte, mirrored when horizontal flip is set
  wire logic [7:0] byte_rev;

  // mono byte reversed bit by bit, ready whether or not flip is set
  for (genvar gi = 0; gi < 8; gi++) begin : g_rev
    assign byte_rev[gi] = pwdata[7-gi];
  end

  function automatic logic [7:0] drwa_pack(input drwa_pkg::drwa_mode_t m,
                                           input logic f, input logic [7:0] d,
                                           input logic [7:0] rv);
    logic [7:0] r;
    r = d;
    case (m)
      drwa_pkg::DRWA_MONO: begin
        r = f ? rv : d;
      end
      drwa_pkg::DRWA_GS4: begin
        if (f) begin
          r = {d[1:0], d[3:2], d[5:4], d[7:6]};
        end
      end
      drwa_pkg::DRWA_GS64A,
      drwa_pkg::DRWA_GS64B: begin
        r = {2'h0, d[5:0]};
      end
      default: begin
        if (f) begin
          r = {d[3:0], d[7:4]};
        end
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pointers: start commands load, data writes step
  logic [7:0] x_r;
  logic [7:0] y_r;
  logic       x_room;
  logic       y_room;

  // saturate rather than wrap so a stray byte never lands in another picture
  assign x_room = (x_r < xmax);
  assign y_room = (y_r < ymax);

  // step decode; saturation rides on x_room and y_room
  logic x_step;
  logic y_step;

  always_comb begin
    case ({y_auto_step_r, x_auto_step_r})
      2'b01: begin
        x_step = x_room;
        y_step = 1'b0;
      end
      2'b10: begin
        x_step = 1'b0;
        y_step = y_room;
      end
      2'b11: begin
        // x parks at its limit while y keeps going up to its own limit, where it parks too
        x_step = x_room;
        y_step = y_room;
      end
      default: begin
        x_step = 1'b0;
        y_step = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_r <= `DRWA_RST_PTR;
    end else if (wr_cmd && code == `DRWA_CODE_XSTART) begin
      x_r <= arg;
    end else if (wr_data && x_step) begin
      x_r <= x_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_r <= `DRWA_RST_PTR;
    end else if (wr_cmd && code == `DRWA_CODE_YSTART) begin
      y_r <= arg;
    end else if (wr_data && y_step) begin
      y_r <= y_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ram write port, one pulse per accepted data byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_wr <= '0;
    end else begin
      ram_wr.valid <= wr_data;
      if (wr_data) begin
        // flip mirrors the column address too; old data is not moved
        ram_wr.x    <= hflip_r ? (xmax - x_r) : x_r;
        ram_wr.y    <= y_r;
        ram_wr.data <= drwa_pack(mode_r, hflip_r, pwdata[7:0], byte_rev);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // display control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp <= '0;
      disp.scan_line_count <= `DRWA_RST_SCAN;
    end else begin
      disp.display_on_bit    <= on_r;
      disp.vertical_flip     <= vflip_r;
      disp.two_colour_en     <= two_r && two_ok;
      disp.grey_level_select <= mode_r;
      disp.scan_line_count   <= scan_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_ptr) begin
      rd_val[7:0]                 = x_r;
      rd_val[`DRWA_PTR_Y +: 8]    = y_r;
    end else if (hit_cfg) begin
      rd_val[2:0]                 = mode_r;
      rd_val[`DRWA_CFG_X_AUTO_STEP]      = x_auto_step_r;
      rd_val[`DRWA_CFG_Y_AUTO_STEP]      = y_auto_step_r;
      rd_val[`DRWA_CFG_HF]        = hflip_r;
      rd_val[`DRWA_CFG_VF]        = vflip_r;
      rd_val[`DRWA_CFG_ON]        = on_r;
      rd_val[`DRWA_CFG_TWO]       = two_r && two_ok;
      rd_val[`DRWA_CFG_SCAN +: 7] = scan_r;
    end
  end

endmodule
`default_nettype wire

/* File: verif/display_ram_write_addressing_tb.sv */
// self-checking bench for the write addressing block
`timescale 1ns/10ps
`default_nettype none
`include "drwa_params.svh"
module display_ram_write_addressing_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, xm, ym, dq[$];
  logic [31:0] pwdata, prdata, r, seed;
  logic [3:0] pstrb;
  drwa_pkg::drwa_ram_wr_t ram_wr, seen[$];
  drwa_pkg::drwa_disp_t disp;
  int error_cnt, samples_checked;
  drwa_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ram_wr(ram_wr), .disp(disp));
  drwa_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (ram_wr.valid === 1'b1) seen.push_back(ram_wr);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] xmax(input logic [2:0] m);
    if (m == 3'h1 || m == 3'h4) return `DRWA_XMAX_MONO;
    return (m == 3'h3) ? `DRWA_XMAX_GS64B : `DRWA_XMAX_GS16;
  endfunction
  function automatic logic [7:0] ymax(input logic [2:0] m);
    if (m == 3'h1 || m == 3'h4) return `DRWA_YMAX_MONO;
    return (m == 3'h3) ? `DRWA_YMAX_GS64B : `DRWA_YMAX_GS16;
  endfunction
  function automatic logic [7:0] pix(input logic [2:0] m, input logic hf, input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (m == 3'h2 || m == 3'h3) begin
      r = {2'b00, v[5:0]};
    end else if (m == 3'h4 && hf) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = v[7-i];
      end
    end
    return r;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] v);
    host_u.xfer(1'b1, `DRWA_OFF_CMD, {16'h0000, c, v}, r, e);
  endtask
  task automatic dat();
    seed = xs(seed);
    dq.push_back(seed[7:0]);
    host_u.xfer(1'b1, `DRWA_OFF_DATA, {24'h000000, seed[7:0]}, r, e);
  endtask
  task automatic pop(input logic [7:0] x, input logic [7:0] y,
                     input logic [2:0] m, input logic hf);
    drwa_pkg::drwa_ram_wr_t w;
    w = seen.pop_front();
    chk({8'h00, w.x, w.y, w.data}, {8'h00, x, y, pix(m, hf, dq.pop_front())});
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    seed = 32'd85560;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({disp.display_on_bit, disp.scan_line_count}, {1'b0, `DRWA_RST_SCAN});
    for (int i = 0; i < 5; i++) begin
      cmd(`DRWA_CODE_GSINC, 8'h30 | i[7:0]);
      xm = xmax(i[2:0]);
      ym = ymax(i[2:0]);
      // x one short, y two short: x parks while y still steps
      cmd(`DRWA_CODE_XSTART, xm - 8'h01);
      cmd(`DRWA_CODE_YSTART, ym - 8'h02);
      repeat (4) dat();
      repeat (2) @(posedge pclk);
      pop(xm - 8'h01, ym - 8'h02, i[2:0], 1'b0);
      pop(xm, ym - 8'h01, i[2:0], 1'b0);
      pop(xm, ym, i[2:0], 1'b0);
      pop(xm, ym, i[2:0], 1'b0);
    end
    for (int s = 0; s < 4; s++) begin
      cmd(`DRWA_CODE_GSINC, {2'b00, s[1:0], 4'h4});
      cmd(`DRWA_CODE_XSTART, 8'h05);
      cmd(`DRWA_CODE_YSTART, 8'h05);
      repeat (2) dat();
      repeat (2) @(posedge pclk);
      pop(8'h05, 8'h05, 3'h4, 1'b0);
      pop(8'h05 + {7'h0, s[0]}, 8'h05 + {7'h0, s[1]}, 3'h4, 1'b0);
    end
    cmd(`DRWA_CODE_DIR, 8'h03);
    cmd(`DRWA_CODE_XSTART, 8'h00);
    cmd(`DRWA_CODE_YSTART, 8'h05);
    dat();
    repeat (2) @(posedge pclk);
    pop(`DRWA_XMAX_MONO, 8'h05, 3'h4, 1'b1);
    chk(disp.vertical_flip, 1'b1);
    cmd(`DRWA_CODE_DIR, 8'h00);
    cmd(`DRWA_CODE_DISPLAY_CONTROL_CMD, 8'h03);
    repeat (3) @(posedge pclk);
    chk({disp.display_on_bit, disp.two_colour_en}, 2'b11);
    cmd(`DRWA_CODE_GSINC, 8'h03);
    repeat (3) @(posedge pclk);
    chk(disp.two_colour_en, 1'b0);
    chk(disp.grey_level_select, 3'h3);
    seed = xs(seed);
    cmd(`DRWA_CODE_SCAN, {1'b0, seed[6:0]});
    repeat (3) @(posedge pclk);
    chk(disp.scan_line_count, seed[6:0]);
    host_u.xfer(1'b0, `DRWA_OFF_CFG, 32'h0, r, e);
    chk(r, {1'b0, seed[6:0], 24'h010003});
    cmd(`DRWA_CODE_XSTART, 8'hE1);
    cmd(`DRWA_CODE_YSTART, 8'h21);
    host_u.xfer(1'b0, `DRWA_OFF_PTR, 32'h0, r, e);
    chk(r[15:0], 16'h21E1);
    host_u.xfer(1'b0, 8'h10, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(disp.display_on_bit, 1'b0);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire

/* File: verif/drwa_host.sv */
// host controller model on the apb port
`timescale 1ns/10ps
`default_nettype none
module drwa_host (
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until the rising edge that samples pready high
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines flip so no stale value looks valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: verif/drwa_props.sv */
// assertions on the write addressing block ports
`timescale 1ns/10ps
`default_nettype none
module drwa_props #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  // outputs
  input wire drwa_pkg::drwa_ram_wr_t ram_wr,
  input wire drwa_pkg::drwa_disp_t   disp
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       dw;
  logic [2:0] gm;
  assign dw = pready && pwrite && paddr == ADDR_W'(8'h04) && pstrb[0];
  assign gm = disp.grey_level_select;
  ////////////////////////////////////////////////////////////////////////////
  AST_WR_PULSE: assert property (dw |=> ram_wr.valid ##1 !ram_wr.valid)
    else $error("data write gave no single ram pulse");
  AST_WR_CAUSE: assert property (ram_wr.valid |-> $past(dw && !pslverr))
    else $error("ram pulse without data write");
  AST_TWO_64: assert property (disp.two_colour_en |-> gm != 3'h2 && gm != 3'h3)
    else $error("two colour in 64 level mode");
  AST_LIM_GS16: assert property (
    ram_wr.valid && gm == 3'h0 |-> ram_wr.x <= 8'h7F && ram_wr.y <= 8'h47)
    else $error("16 level pointer out of range");
  AST_LIM_GS4: assert property (
    ram_wr.valid && gm == 3'h1 |-> ram_wr.x <= 8'h3F && ram_wr.y <= 8'h8F)
    else $error("4 level pointer out of range");
  AST_LIM_GS64A: assert property (
    ram_wr.valid && gm == 3'h2 |-> ram_wr.x <= 8'h7F && ram_wr.y <= 8'h47
      && ram_wr.data[7:6] == 2'b00)
    else $error("64 level mode 1 write wrong");
  AST_LIM_GS64B: assert property (
    ram_wr.valid && gm == 3'h3 |-> ram_wr.y <= 8'h23)
    else $error("64 level mode 2 y out of range");
  AST_PIX_GS64B: assert property (
    ram_wr.valid && gm == 3'h3 |-> ram_wr.data[7:6] == 2'b00)
    else $error("64 level mode 2 pixel not 6 bit");
  AST_LIM_MONO: assert property (
    ram_wr.valid && gm == 3'h4 |-> ram_wr.x <= 8'h3F && ram_wr.y <= 8'h8F)
    else $error("mono pointer out of range");
  AST_OFF_RST: assert property (
    $rose(presetn) |-> !disp.display_on_bit && disp.scan_line_count == 7'h47)
    else $error("display state not cleared by reset");
endmodule
bind drwa_top drwa_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
  .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .ram_wr(ram_wr), .disp(disp));
`default_nettype wire
